/* common/mie_pkg.sv */
// shared opcodes, carriers and constants for the execute datapath
package mie_pkg;

  // ----------------------------------------
  // widths and constants
  // ----------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DADDR_W     = 12;
  localparam int unsigned PADDR_W     = 16;
  localparam int unsigned PWORD_W     = 16;
  localparam logic [7:0]  LAST_PAGE   = 8'hFF;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;
  localparam logic [7:0]  ONE_BYTE    = 8'h01;
  localparam logic [3:0]  BCD_LIMIT   = 4'h9;
  localparam logic [3:0]  BCD_FIX     = 4'h6;
  localparam logic [7:0]  ACC_RST     = 8'h00;
  localparam logic [7:0]  TBL_RST     = 8'h00;

  // ----------------------------------------
  // operations
  // ----------------------------------------
  typedef enum logic [4:0] {
    OP_NOP                  = 5'b00000,
    OP_COPY_TEST_SKIP       = 5'b00001,
    OP_ZERO_SKIP_BIT        = 5'b00010,
    OP_PAGE_TABLE_READ      = 5'b00011,
    OP_LAST_PAGE_TABLE_READ = 5'b00100,
    OP_PREINC_TABLE_READ    = 5'b00101,
    OP_PREINC_LAST_READ     = 5'b00110,
    OP_XOR_ACC              = 5'b00111,
    OP_XOR_MEM              = 5'b01000,
    OP_XOR_IMM              = 5'b01001,
    OP_ADD_CARRY            = 5'b01010,
    OP_ADD_CARRY_MEM        = 5'b01011,
    OP_ADD                  = 5'b01100,
    OP_ADD_MEM              = 5'b01101,
    OP_AND                  = 5'b01110,
    OP_AND_MEM              = 5'b01111,
    OP_OR                   = 5'b10000,
    OP_OR_MEM               = 5'b10001,
    OP_CLEAR                = 5'b10010,
    OP_CLEAR_BIT            = 5'b10011,
    OP_INVERT               = 5'b10100,
    OP_INVERT_ACC           = 5'b10101,
    OP_DECIMAL_ADJUST       = 5'b10110,
    OP_DECREMENT            = 5'b10111,
    OP_DECREMENT_ACC        = 5'b11000,
    OP_INCREMENT            = 5'b11001,
    OP_INCREMENT_ACC        = 5'b11010,
    OP_MOVE_TO_ACC          = 5'b11011,
    OP_MOVE_TO_MEM          = 5'b11100,
    OP_ROTATE_LEFT          = 5'b11101
  } mie_op_e;

  typedef struct packed {
    mie_op_e              op;
    logic [DADDR_W-1:0]   addr;
    logic [2:0]           bit_sel;
    logic [DATA_W-1:0]    imm;
  } mie_instr_s;

  typedef struct packed {
    logic ovf;
    logic zero;
    logic aux_carry;
    logic carry;
    logic signed_cmp;
    logic carry_zero;
  } mie_flags_s;

  localparam mie_flags_s FLAGS_RST = '{default: 1'b0};

endpackage

/* hw/mie_exec.sv */
// execute datapath: skips, table reads, xor and the extended instruction group
//
// Operation
// - copy-test skip loads accumulator with byte, skips when byte zero, flags kept.
// - bit-test skip skips when selected bit is zero, no flag change.
// - taken skip adds one dummy cycle, two instruction cycles total.
// - page table read: program word at pointer pair, low to memory, high to table_high_byte.
// - last-page table read uses final page and low pointer only.
// - pre-increment table read bumps low pointer, then reads at pointer pair.
// - pre-increment last-page read bumps low pointer, then reads final page.
// - xor with byte or immediate, to accumulator or memory, zero flag only.
// - extended group addresses any data memory section directly, no bank.
// - add with carry sets overflow, zero, aux carry, carry, signed compare.
// - add without carry affects the same five flags.
// - and to accumulator or memory, zero flag only.
// - or to accumulator or memory, zero flag only.
// - clear zeroes whole byte or one bit, flags unchanged.
// - invert byte to memory or accumulator only, zero flag updated.
// - decimal adjust adds six per nibble over nine or carried, into memory.
// - decimal adjust touches carry only, setting it when the high nibble is over nine or carry is already set.
// - decrement byte to memory or accumulator only, zero flag updated.
// - increment byte to memory or accumulator only, zero flag updated.
// - move byte to accumulator or accumulator to byte, flags kept.
// - rotate byte left, old bit seven into bit zero.
module mie_exec (
  input  wire logic                             clk_sys,
  input  wire logic                             rst,
  input  wire logic                             instr_valid,
  input  wire mie_pkg::mie_instr_s              instr,
  output logic                                  dummy_cycle,
  output logic [mie_pkg::DADDR_W-1:0]           mem_raddr,
  input  wire logic [mie_pkg::DATA_W-1:0]       mem_rdata,
  output logic                                  mem_we,
  output logic [mie_pkg::DADDR_W-1:0]           mem_waddr,
  output logic [mie_pkg::DATA_W-1:0]            mem_wdata,
  output logic [mie_pkg::PADDR_W-1:0]           prog_addr,
  input  wire logic [mie_pkg::PWORD_W-1:0]      prog_rdata,
  input  wire logic                             ptr_low_wr,
  input  wire logic                             ptr_high_wr,
  input  wire logic [mie_pkg::DATA_W-1:0]       ptr_wdata,
  output logic [mie_pkg::DATA_W-1:0]            accumulator,
  output mie_pkg::mie_flags_s                   flags,
  output logic [mie_pkg::DATA_W-1:0]            table_high_byte,
  output logic [mie_pkg::DATA_W-1:0]            table_pointer_low,
  output logic [mie_pkg::DATA_W-1:0]            table_pointer_high,
  output logic                                  skip_pending
);

  // ----------------------------------------
  // issue and operand fetch
  // ----------------------------------------
  logic                 exec;
  logic [7:0]           m;
  logic [7:0]           acc;
  logic [7:0]           table_pointer_low_inc;
  logic [7:0]           table_pointer_low_use;
  logic                 take_skip;

  assign acc         = accumulator;
  assign m           = mem_rdata;
  assign exec        = instr_valid & ~skip_pending;
  assign dummy_cycle = instr_valid & skip_pending;
  assign mem_raddr   = instr.addr;
  assign table_pointer_low_inc    = table_pointer_low + mie_pkg::ONE_BYTE;

  always_comb begin
    table_pointer_low_use = table_pointer_low;
    if (instr.op == mie_pkg::OP_PREINC_TABLE_READ || instr.op == mie_pkg::OP_PREINC_LAST_READ) begin
      table_pointer_low_use = table_pointer_low_inc;
    end
  end

  // last page from low pointer only
  always_comb begin
    if (instr.op == mie_pkg::OP_LAST_PAGE_TABLE_READ || instr.op == mie_pkg::OP_PREINC_LAST_READ) begin
      prog_addr = {mie_pkg::LAST_PAGE, table_pointer_low_use};
    end else begin
      prog_addr = {table_pointer_high, table_pointer_low_use};
    end
  end

  // ----------------------------------------
  // arithmetic
  // ----------------------------------------
  logic                 cin;
  logic [8:0]           sum9;
  logic [4:0]           sum_lo;
  logic [7:0]           sum;
  logic                 sum_ov;
  logic                 lo_adj;
  logic                 hi_adj;
  logic [7:0]           daa_res;

  assign cin     = (instr.op == mie_pkg::OP_ADD_CARRY || instr.op == mie_pkg::OP_ADD_CARRY_MEM) & flags.carry;
  assign sum9    = {1'b0, acc} + {1'b0, m} + {8'h00, cin};
  assign sum_lo  = {1'b0, acc[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
  assign sum     = sum9[7:0];
  assign sum_ov  = (acc[7] == m[7]) & (sum[7] != acc[7]);
  assign lo_adj  = (acc[3:0] > mie_pkg::BCD_LIMIT) | flags.aux_carry;
  assign hi_adj  = (acc[7:4] > mie_pkg::BCD_LIMIT) | flags.carry;
  assign daa_res = acc + {(hi_adj ? mie_pkg::BCD_FIX : 4'h0), (lo_adj ? mie_pkg::BCD_FIX : 4'h0)};

  // ----------------------------------------
  // result selection
  // ----------------------------------------
  logic [7:0]           res;
  logic                 to_acc;
  logic                 to_mem;
  logic                 upd_z;
  logic                 upd_add;
  logic                 tbl_rd;

  always_comb begin
    res     = mie_pkg::ZERO_BYTE;
    to_acc  = 1'b0;
    to_mem  = 1'b0;
    upd_z   = 1'b0;
    upd_add = 1'b0;
    tbl_rd  = 1'b0;
    case (instr.op)
      mie_pkg::OP_COPY_TEST_SKIP: begin
        res    = m;
        to_acc = 1'b1;
      end
      mie_pkg::OP_PAGE_TABLE_READ,
      mie_pkg::OP_LAST_PAGE_TABLE_READ,
      mie_pkg::OP_PREINC_TABLE_READ,
      mie_pkg::OP_PREINC_LAST_READ: begin
        res    = prog_rdata[7:0];
        to_mem = 1'b1;
        tbl_rd = 1'b1;
      end
      mie_pkg::OP_XOR_ACC: begin res = acc ^ m; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_XOR_MEM: begin res = acc ^ m; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_XOR_IMM: begin res = acc ^ instr.imm; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_ADD_CARRY: begin res = sum; to_acc = 1'b1; upd_add = 1'b1; end
      mie_pkg::OP_ADD_CARRY_MEM: begin res = sum; to_mem = 1'b1; upd_add = 1'b1; end
      mie_pkg::OP_ADD: begin res = sum; to_acc = 1'b1; upd_add = 1'b1; end
      mie_pkg::OP_ADD_MEM: begin res = sum; to_mem = 1'b1; upd_add = 1'b1; end
      mie_pkg::OP_AND: begin res = acc & m; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_AND_MEM: begin res = acc & m; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_OR: begin res = acc | m; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_OR_MEM: begin res = acc | m; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_CLEAR: begin res = mie_pkg::ZERO_BYTE; to_mem = 1'b1; end
      mie_pkg::OP_CLEAR_BIT: begin res = m & ~(mie_pkg::ONE_BYTE << instr.bit_sel); to_mem = 1'b1; end
      mie_pkg::OP_INVERT: begin res = ~m; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_INVERT_ACC: begin res = ~m; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_DECIMAL_ADJUST: begin res = daa_res; to_mem = 1'b1; end
      mie_pkg::OP_DECREMENT: begin res = m - mie_pkg::ONE_BYTE; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_DECREMENT_ACC: begin res = m - mie_pkg::ONE_BYTE; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_INCREMENT: begin res = m + mie_pkg::ONE_BYTE; to_mem = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_INCREMENT_ACC: begin res = m + mie_pkg::ONE_BYTE; to_acc = 1'b1; upd_z = 1'b1; end
      mie_pkg::OP_MOVE_TO_ACC: begin res = m; to_acc = 1'b1; end
      mie_pkg::OP_MOVE_TO_MEM: begin res = acc; to_mem = 1'b1; end
      // bit seven wraps to bit zero
      mie_pkg::OP_ROTATE_LEFT: begin res = {m[6:0], m[7]}; to_mem = 1'b1; end
      default: begin
        res = mie_pkg::ZERO_BYTE;
      end
    endcase
  end

  assign take_skip = exec & (((instr.op == mie_pkg::OP_COPY_TEST_SKIP) & (m == mie_pkg::ZERO_BYTE))
                   | ((instr.op == mie_pkg::OP_ZERO_SKIP_BIT) & ~m[instr.bit_sel]));

  // ----------------------------------------
  // state updates
  // ----------------------------------------
  // one dummy slot per taken skip
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skip_pending <= 1'b0;
    end else if (take_skip) begin
      skip_pending <= 1'b1;
    end else if (instr_valid) begin
      skip_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      accumulator <= mie_pkg::ACC_RST;
    end else if (exec & to_acc) begin
      accumulator <= res;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= mie_pkg::ZERO_BYTE;
    end else begin
      mem_we    <= exec & to_mem;
      mem_waddr <= instr.addr;
      mem_wdata <= res;
    end
  end

  // carry_zero is never touched by this instruction set
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags <= mie_pkg::FLAGS_RST;
    end else if (exec) begin
      if (upd_z | upd_add) begin
        flags.zero <= (res == mie_pkg::ZERO_BYTE);
      end
      if (upd_add) begin
        flags.ovf        <= sum_ov;
        flags.aux_carry  <= sum_lo[4];
        flags.carry      <= sum9[8];
        flags.signed_cmp <= sum_ov ^ sum[7];
      end
      if (instr.op == mie_pkg::OP_DECIMAL_ADJUST && hi_adj) begin
        flags.carry <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_high_byte <= mie_pkg::TBL_RST;
    end else if (exec & tbl_rd) begin
      table_high_byte <= prog_rdata[15:8];
    end
  end

  // port writes win over the instruction's own bump
  // low pointer kept incremented
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_pointer_low <= mie_pkg::TBL_RST;
    end else if (ptr_low_wr) begin
      table_pointer_low <= ptr_wdata;
    end else if (exec) begin
      table_pointer_low <= table_pointer_low_use;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      table_pointer_high <= mie_pkg::TBL_RST;
    end else if (ptr_high_wr) begin
      table_pointer_high <= ptr_wdata;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_dummy_no_effect: assert property (dummy_cycle
    |=> !mem_we && accumulator == $past(accumulator) && flags == $past(flags) && !skip_pending)
    else $error("dummy cycle changed state");
  a_skip_two_cycles: assert property (skip_pending && instr_valid |-> dummy_cycle ##1 !skip_pending)
    else $error("taken skip not exactly one dummy");
  a_copy_skip_zero: assert property (exec && instr.op == mie_pkg::OP_COPY_TEST_SKIP && m == 8'h00
    |=> skip_pending && accumulator == 8'h00 && flags == $past(flags))
    else $error("copy-test skip wrong");
  a_bit_skip_set: assert property (exec && instr.op == mie_pkg::OP_ZERO_SKIP_BIT
    |=> skip_pending == !$past(m[instr.bit_sel]) && flags == $past(flags))
    else $error("bit-test skip wrong");
  a_table_bytes: assert property (exec && instr.op == mie_pkg::OP_PAGE_TABLE_READ
    |-> prog_addr == {table_pointer_high, table_pointer_low} ##1 mem_we
    && mem_wdata == $past(prog_rdata[7:0]) && table_high_byte == $past(prog_rdata[15:8]))
    else $error("table read bytes misplaced");
  a_last_page_addr: assert property (exec && instr.op == mie_pkg::OP_LAST_PAGE_TABLE_READ
    |-> prog_addr == {mie_pkg::LAST_PAGE, table_pointer_low})
    else $error("last page address wrong");
  a_preinc_pointer: assert property (exec && !ptr_low_wr && instr.op == mie_pkg::OP_PREINC_TABLE_READ
    |-> prog_addr == {table_pointer_high, 8'(table_pointer_low + 8'h01)}
    ##1 table_pointer_low == 8'($past(table_pointer_low) + 8'h01))
    else $error("pre-increment pointer wrong");
  a_xor_zero_flag: assert property (exec && instr.op == mie_pkg::OP_XOR_ACC
    |=> accumulator == ($past(acc) ^ $past(m)) && flags.zero == (accumulator == 8'h00)
    && flags.carry == $past(flags.carry) && flags.ovf == $past(flags.ovf))
    else $error("xor result or flags wrong");
  a_add_carry_out: assert property (exec && instr.op == mie_pkg::OP_ADD
    |=> {flags.carry, accumulator} == 9'($past(acc)) + 9'($past(m)))
    else $error("add result or carry wrong");
  a_clear_keeps_flags: assert property (exec && instr.op == mie_pkg::OP_CLEAR
    |=> mem_we && mem_wdata == 8'h00 && flags == $past(flags))
    else $error("clear wrong");
  a_daa_carry_sticky: assert property (exec && instr.op == mie_pkg::OP_DECIMAL_ADJUST
    |=> flags.carry == ($past(flags.carry) || $past(acc[7:4]) > 4'h9)
    && flags.zero == $past(flags.zero) && flags.ovf == $past(flags.ovf)
    && flags.aux_carry == $past(flags.aux_carry))
    else $error("decimal adjust flags wrong");
  a_inc_acc_only: assert property (exec && instr.op == mie_pkg::OP_INCREMENT_ACC
    |=> !mem_we && accumulator == $past(m) + 8'h01)
    else $error("increment to accumulator wrong");

endmodule

/* sim/mcu_instruction_execution_test.sv */
// self-checking bench for the execute datapath
module mcu_instruction_execution_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys, rst, instr_valid, dummy_cycle, mem_we, ptr_low_wr, ptr_high_wr, skip_pending;
  mie_pkg::mie_instr_s instr;
  mie_pkg::mie_flags_s flags, e_flg;
  logic [11:0] mem_raddr, mem_waddr, e_wa;
  logic [15:0] prog_addr, prog_rdata;
  logic [7:0]  mem_rdata, mem_wdata, ptr_wdata, accumulator, table_high_byte, table_pointer_low, table_pointer_high;
  logic [7:0]  e_acc, e_tpl, e_tph, e_tbh, e_wd;
  logic        e_pend, e_we;
  logic [31:0] seed = 32'h00013272;
  int          num_errors = 0;
  int          cmp_count = 0;

  mie_exec mie_exec_inst (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .dummy_cycle(dummy_cycle), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
    .ptr_low_wr(ptr_low_wr), .ptr_high_wr(ptr_high_wr), .ptr_wdata(ptr_wdata), .accumulator(accumulator),
    .flags(flags), .table_high_byte(table_high_byte), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high), .skip_pending(skip_pending));
  mie_mem_model mie_mem_model_inst (.clk_sys(clk_sys), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
    .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .prog_addr(prog_addr),
    .prog_rdata(prog_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic put(input logic to_mem, input logic [11:0] a, input logic [7:0] v);
    if (to_mem) begin
      e_we = 1'b1;
      e_wa = a;
      e_wd = v;
    end else begin
      e_acc = v;
    end
  endtask

  task automatic zput(input logic to_mem, input logic [11:0] a, input logic [7:0] v);
    e_flg.zero = (v == 8'h00);
    put(to_mem, a, v);
  endtask

  // ----------------------------------------
  // expected behaviour of one presented instruction
  // ----------------------------------------
  task automatic model(input mie_pkg::mie_instr_s i, input logic [7:0] m);
    logic [8:0]  sum;
    logic [4:0]  lo;
    logic [7:0]  cr;
    logic [15:0] pa;
    logic        c;
    e_we = 1'b0;
    if (e_pend) begin
      e_pend = 1'b0;
      return;
    end
    case (i.op)
      mie_pkg::OP_COPY_TEST_SKIP: begin
        e_acc = m;
        e_pend = (m == 8'h00);
      end
      mie_pkg::OP_ZERO_SKIP_BIT: e_pend = !m[i.bit_sel];
      mie_pkg::OP_PAGE_TABLE_READ, mie_pkg::OP_LAST_PAGE_TABLE_READ, mie_pkg::OP_PREINC_TABLE_READ,
      mie_pkg::OP_PREINC_LAST_READ: begin
        if (i.op inside {mie_pkg::OP_PREINC_TABLE_READ, mie_pkg::OP_PREINC_LAST_READ}) e_tpl = e_tpl + 8'h01;
        pa = (i.op inside {mie_pkg::OP_LAST_PAGE_TABLE_READ, mie_pkg::OP_PREINC_LAST_READ}) ?
             {mie_pkg::LAST_PAGE, e_tpl} : {e_tph, e_tpl};
        e_tbh = pa[7:0] ^ 8'h3C;
        put(1'b1, i.addr, pa[15:8] + pa[7:0]);
      end
      mie_pkg::OP_XOR_ACC, mie_pkg::OP_XOR_MEM: zput(i.op == mie_pkg::OP_XOR_MEM, i.addr, e_acc ^ m);
      mie_pkg::OP_XOR_IMM: zput(1'b0, i.addr, e_acc ^ i.imm);
      mie_pkg::OP_AND, mie_pkg::OP_AND_MEM: zput(i.op == mie_pkg::OP_AND_MEM, i.addr, e_acc & m);
      mie_pkg::OP_OR, mie_pkg::OP_OR_MEM: zput(i.op == mie_pkg::OP_OR_MEM, i.addr, e_acc | m);
      mie_pkg::OP_ADD_CARRY, mie_pkg::OP_ADD_CARRY_MEM, mie_pkg::OP_ADD, mie_pkg::OP_ADD_MEM: begin
        c = (i.op inside {mie_pkg::OP_ADD_CARRY, mie_pkg::OP_ADD_CARRY_MEM}) && e_flg.carry;
        sum = {1'b0, e_acc} + {1'b0, m} + {8'h00, c};
        lo = {1'b0, e_acc[3:0]} + {1'b0, m[3:0]} + {4'h0, c};
        e_flg.carry = sum[8];
        e_flg.aux_carry = lo[4];
        e_flg.ovf = (e_acc[7] == m[7]) && (sum[7] != e_acc[7]);
        e_flg.signed_cmp = e_flg.ovf ^ sum[7];
        zput(i.op inside {mie_pkg::OP_ADD_CARRY_MEM, mie_pkg::OP_ADD_MEM}, i.addr, sum[7:0]);
      end
      mie_pkg::OP_CLEAR: put(1'b1, i.addr, 8'h00);
      mie_pkg::OP_CLEAR_BIT: put(1'b1, i.addr, m & ~(8'h01 << i.bit_sel));
      mie_pkg::OP_INVERT, mie_pkg::OP_INVERT_ACC: zput(i.op == mie_pkg::OP_INVERT, i.addr, ~m);
      mie_pkg::OP_DECREMENT, mie_pkg::OP_DECREMENT_ACC: zput(i.op == mie_pkg::OP_DECREMENT, i.addr, m - 8'h01);
      mie_pkg::OP_INCREMENT, mie_pkg::OP_INCREMENT_ACC: zput(i.op == mie_pkg::OP_INCREMENT, i.addr, m + 8'h01);
      mie_pkg::OP_DECIMAL_ADJUST: begin
        cr = {(e_acc[7:4] > 4'h9 || e_flg.carry) ? 4'h6 : 4'h0, (e_acc[3:0] > 4'h9 || e_flg.aux_carry) ? 4'h6 : 4'h0};
        e_flg.carry = e_flg.carry || (cr[7:4] != 4'h0);
        put(1'b1, i.addr, e_acc + cr);
      end
      mie_pkg::OP_MOVE_TO_ACC, mie_pkg::OP_MOVE_TO_MEM: put(i.op == mie_pkg::OP_MOVE_TO_MEM, i.addr,
                                                            (i.op == mie_pkg::OP_MOVE_TO_MEM) ? e_acc : m);
      mie_pkg::OP_ROTATE_LEFT: put(1'b1, i.addr, {m[6:0], m[7]});
      default: ;
    endcase
  endtask

  // one instruction, then an idle cycle in which the results are compared
  task automatic run_op(input mie_pkg::mie_instr_s ins);
    @(negedge clk_sys);
    instr_valid = 1'b1;
    instr = ins;
    ptr_low_wr = 1'b0;
    ptr_high_wr = 1'b0;
    #1;
    check("dummy_cycle", 16'(dummy_cycle), 16'(e_pend));
    check("mem_raddr", 16'(mem_raddr), 16'(ins.addr));
    model(ins, mie_mem_model_inst.dmem[ins.addr]);
    @(negedge clk_sys);
    instr_valid = 1'b0;
    check("mem_we", 16'(mem_we), 16'(e_we));
    if (e_we) begin
      check("mem_waddr", 16'(mem_waddr), 16'(e_wa));
      check("mem_wdata", 16'(mem_wdata), 16'(e_wd));
    end
    check("accumulator", 16'(accumulator), 16'(e_acc));
    check("flags", 16'(flags), 16'(e_flg));
    check("table_high_byte", 16'(table_high_byte), 16'(e_tbh));
    check("table_pointer_low", 16'(table_pointer_low), 16'(e_tpl));
    check("table_pointer_high", 16'(table_pointer_high), 16'(e_tph));
    check("skip_pending", 16'(skip_pending), 16'(e_pend));
  endtask

  task automatic set_ptr(input logic hi, input logic [7:0] v);
    @(negedge clk_sys);
    ptr_wdata = v;
    ptr_low_wr = !hi;
    ptr_high_wr = hi;
    if (hi) e_tph = v;
    else e_tpl = v;
  endtask

  function automatic mie_pkg::mie_instr_s mk(input mie_pkg::mie_op_e op, input logic [11:0] a);
    return '{op: op, addr: a, bit_sel: 3'h0, imm: 8'h00};
  endfunction

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    mie_pkg::mie_instr_s ri;
    logic [31:0] r;
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    {ptr_low_wr, ptr_high_wr, ptr_wdata} = '0;
    {e_acc, e_tpl, e_tph, e_tbh, e_pend, e_we, e_wa, e_wd} = '0;
    e_flg = mie_pkg::FLAGS_RST;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    check("acc_rst", 16'(accumulator), 16'(mie_pkg::ACC_RST));
    check("flags_rst", 16'(flags), 16'(mie_pkg::FLAGS_RST));
    check("tpl_rst", 16'(table_pointer_low), 16'(mie_pkg::TBL_RST));
    check("tph_rst", 16'(table_pointer_high), 16'(mie_pkg::TBL_RST));
    check("misc_rst", 16'({mem_we, skip_pending, table_high_byte}), 16'h0000);
    $display("reset test done");
    // low pointer wraps on pre-increment, high pointer must not follow
    set_ptr(1'b1, 8'h12);
    set_ptr(1'b0, 8'hFF);
    run_op(mk(mie_pkg::OP_PREINC_TABLE_READ, 12'hF3A));
    set_ptr(1'b0, 8'hFF);
    run_op(mk(mie_pkg::OP_PREINC_LAST_READ, 12'h07C));
    // zero byte skip drops the following add
    run_op(mk(mie_pkg::OP_CLEAR, 12'h800));
    run_op(mk(mie_pkg::OP_COPY_TEST_SKIP, 12'h800));
    run_op(mk(mie_pkg::OP_ADD_MEM, 12'h801));
    $display("corner tests done");
    for (int n = 0; n < 1500; n++) begin
      r = rnd();
      ri = '{op: mie_pkg::mie_op_e'(5'(r % 32'd30)), addr: r[19:8], bit_sel: r[22:20], imm: r[31:24]};
      if (r[7:5] == 3'h0) set_ptr(r[23], 8'(rnd() >> 24));
      run_op(ri);
    end
    $display("random tests done");
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end
endmodule

/* sim/mie_mem_model.sv */
// behavioural data and program memory on the far side of the execute datapath
module mie_mem_model (
  input  wire logic                        clk_sys,
  input  wire logic [mie_pkg::DADDR_W-1:0] mem_raddr,
  output logic      [mie_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic                        mem_we,
  input  wire logic [mie_pkg::DADDR_W-1:0] mem_waddr,
  input  wire logic [mie_pkg::DATA_W-1:0]  mem_wdata,
  input  wire logic [mie_pkg::PADDR_W-1:0] prog_addr,
  output logic      [mie_pkg::PWORD_W-1:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] dmem [0:4095];

  // scrambled fill so that reads differ per address, a few bytes zero
  initial begin
    for (int i = 0; i < 4096; i++) begin
      dmem[i] = 8'(i * 37) ^ 8'hA5;
    end
  end

  // async read, data valid in the same cycle as the address
  assign mem_rdata = dmem[mem_raddr];
  // high and low byte differ so a swapped pair shows up
  assign prog_rdata = {prog_addr[7:0] ^ 8'h3C, prog_addr[15:8] + prog_addr[7:0]};

  always @(posedge clk_sys) begin
    if (mem_we) begin
      dmem[mem_waddr] <= mem_wdata;
    end
  end
endmodule
